// File: rtl/gearbox_pkg.sv
package gearbox_pkg;

  // =====================================================================
  // Modes of the input gearbox
  // =====================================================================
  typedef enum logic [1:0] {
    MODE_VIDEO_SEVEN,   // 1:7 video receive
    MODE_DDR_EIGHT,     // generic_ddr_one_to_eight
    MODE_DDR_DUAL_FOUR  // two generic_ddr_one_to_four
  } gear_mode_t;

  // =====================================================================
  // Widths and word lengths
  // =====================================================================
  localparam int unsigned      PAR_WIDTH    = 8;
  localparam int unsigned      CNT_WIDTH    = 4;
  localparam int unsigned      LANE_COUNT   = 2;
  localparam logic [3:0]       LEN_VIDEO    = 4'h7;
  localparam logic [3:0]       LEN_EIGHT    = 4'h8;
  localparam logic [3:0]       LEN_FOUR     = 4'h4;
  localparam logic [3:0]       LEN_NONE     = 4'h0;

  // Lane indices and output field positions
  localparam int unsigned      LANE_FIRST   = 0;
  localparam int unsigned      LANE_THIRD   = 1;
  localparam int unsigned      HALF_LSB     = 0;
  localparam int unsigned      HALF_MSB     = 3;
  localparam int unsigned      UPPER_LSB    = 4;
  localparam int unsigned      UPPER_MSB    = 7;
  localparam int unsigned      VIDEO_MSB    = 6;
  localparam int unsigned      UNUSED_BIT   = 7;

endpackage : gearbox_pkg

// File: rtl/gearbox_lane.sv
`timescale 1ns/1ps

// =====================================================================
// One deserializing lane: collects bits into words of a chosen length
// =====================================================================
module gearbox_lane #(
  parameter int unsigned W  = gearbox_pkg::PAR_WIDTH,
  parameter int unsigned CW = gearbox_pkg::CNT_WIDTH
) (
  // Clock and reset
  input  wire logic          mclk,
  input  wire logic          reset_n,
  // Bit stream
  input  wire logic          clear,
  input  wire logic          bit_strobe,
  input  wire logic          bit_in,
  input  wire logic [CW-1:0] word_len,
  input  wire logic          slip_req,
  // Word out
  output logic      [W-1:0]  word,
  output logic               word_done,
  output logic      [CW-1:0] bit_count
);
  import gearbox_pkg::*;

  typedef struct packed {
    logic [W-1:0]  shift;
    logic [W-1:0]  word;
    logic [CW-1:0] count;
    logic          done;
    logic          slip_pend;
  } lane_state_t;

  lane_state_t q, d;

  // Mask keeping the low len bits of a word
  function automatic logic [W-1:0] low_mask(input logic [CW-1:0] len);
    logic [W-1:0] m;
    m = '0;
    for (int i = 0; i < W; i++) begin
      m[i] = (i < len);
    end
    return m;
  endfunction : low_mask

  // Next state: a slip absorbs one bit without advancing the count,
  // moving the word boundary one bit later
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (slip_req) begin
      d.slip_pend = 1'b1;
    end
    if (clear) begin
      d = '0;
    end else if (bit_strobe) begin
      d.shift = {q.shift[W-2:0], bit_in};
      if (q.slip_pend) begin
        d.slip_pend = slip_req;                                   // RULE5
      end else if (q.count == word_len - CW'(1)) begin
        d.word  = {q.shift[W-2:0], bit_in} & low_mask(word_len);
        d.count = '0;
        d.done  = 1'b1;
      end else begin
        d.count = q.count + CW'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign word      = q.word;
  assign word_done = q.done;
  assign bit_count = q.count;

endmodule : gearbox_lane

// File: rtl/input_deserializer_gearbox.sv
`timescale 1ns/1ps

// How it works
// (RULE1) Gearbox works as 1:7 deserializer, one 1:8, or two 1:4 DDR gearboxes.
// (RULE2) Video 1:7 words appear on bits 6..0; bit 7 stays zero.
// (RULE3) In 1:8 mode each word fills all bits 7..0.
// (RULE4) Dual 1:4: first slot drives bits 7..4, third slot bits 3..0.
// (RULE5) Core align request shifts the word boundary by one serial bit.
// (RULE6) Serial input is the first pad's delayed high-speed data.
// (RULE7) Bits taken on both clock edges; slow clock is edge clock over half width.

module input_deserializer_gearbox (
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  // Configuration
  input  wire gearbox_pkg::gear_mode_t mode,
  // Serial side, outside this clock domain
  input  wire logic                   fast_edge_clock,
  input  wire logic                   serial_first,
  input  wire logic                   serial_third,
  // Core controls, same clock
  input  wire logic                   word_align_request,
  input  wire logic                   word_align_request_third,
  // Parallel side
  output logic [gearbox_pkg::PAR_WIDTH-1:0] parallel_q,
  output logic [gearbox_pkg::LANE_COUNT-1:0] word_valid,
  output logic                        slow_clock
);
  import gearbox_pkg::*;

  typedef struct packed {
    logic [1:0]            eclk_sync;
    logic                  eclk_last;
    logic [1:0]            first_sync;
    logic [1:0]            third_sync;
    logic [LANE_COUNT-1:0] align_last;
    gear_mode_t            mode_last;
    logic [PAR_WIDTH-1:0]  par;
    logic [LANE_COUNT-1:0] valid;
    logic                  slow;
  } top_state_t;

  top_state_t q, d;

  // =====================================================================
  // Lane wiring
  // =====================================================================
  logic                  bit_strobe;
  logic                  mode_change;
  logic [LANE_COUNT-1:0] lane_bit;
  logic [LANE_COUNT-1:0] lane_slip;
  logic [LANE_COUNT-1:0] lane_clear;
  logic [LANE_COUNT-1:0] lane_done;
  logic [LANE_COUNT-1:0] align_now;
  logic [CNT_WIDTH-1:0]  lane_len   [LANE_COUNT];
  logic [CNT_WIDTH-1:0]  lane_cnt   [LANE_COUNT];
  logic [PAR_WIDTH-1:0]  lane_word  [LANE_COUNT];

  // Word length each lane runs at for a given mode
  function automatic logic [CNT_WIDTH-1:0] len_of(input gear_mode_t m, input int lane);
    logic [CNT_WIDTH-1:0] l;
    l = LEN_NONE;
    unique case (m)
      MODE_VIDEO_SEVEN:   l = (lane == LANE_FIRST) ? LEN_VIDEO : LEN_NONE;  // RULE1
      MODE_DDR_EIGHT:     l = (lane == LANE_FIRST) ? LEN_EIGHT : LEN_NONE;  // RULE1
      MODE_DDR_DUAL_FOUR: l = LEN_FOUR;                                     // RULE1
      default:            l = LEN_NONE;
    endcase
    return l;
  endfunction : len_of

  // Either edge of the sampled edge clock carries one bit
  assign bit_strobe  = q.eclk_sync[1] ^ q.eclk_last;                       // RULE7
  assign mode_change = (mode != q.mode_last);
  assign align_now   = {word_align_request_third, word_align_request};
  assign lane_bit    = {q.third_sync[1], q.first_sync[1]};                  // RULE6

  // =====================================================================
  // Two lanes; the third-slot lane idles outside dual mode
  // =====================================================================
  generate
    for (genvar g = 0; g < LANE_COUNT; g++) begin : g_lane
      assign lane_len[g]   = len_of(mode, g);
      assign lane_clear[g] = mode_change || (lane_len[g] == LEN_NONE);
      // Only a rising request slips, so a held level cannot walk the boundary
      assign lane_slip[g]  = align_now[g] && !q.align_last[g];             // RULE5

      gearbox_lane #(
        .W  (PAR_WIDTH),
        .CW (CNT_WIDTH)
      ) u_lane (
        .mclk       (mclk),
        .reset_n    (reset_n),
        .clear      (lane_clear[g]),
        .bit_strobe (bit_strobe),
        .bit_in     (lane_bit[g]),
        .word_len   (lane_len[g]),
        .slip_req   (lane_slip[g]),
        .word       (lane_word[g]),
        .word_done  (lane_done[g]),
        .bit_count  (lane_cnt[g])
      );
    end
  endgenerate

  // =====================================================================
  // Synchronisers, output placement and slow clock
  // =====================================================================
  always_comb begin
    d = q;
    // Two flops on every pad-side input before use
    d.eclk_sync  = {q.eclk_sync[0], fast_edge_clock};
    d.eclk_last  = q.eclk_sync[1];
    d.first_sync = {q.first_sync[0], serial_first};
    d.third_sync = {q.third_sync[0], serial_third};
    d.align_last = align_now;
    d.mode_last  = mode;
    d.valid      = '0;
    if (mode_change) begin
      d.par = '0;
    end else begin
      unique case (mode)
        MODE_VIDEO_SEVEN: begin
          if (lane_done[LANE_FIRST]) begin
            d.par[VIDEO_MSB:0]  = lane_word[LANE_FIRST][VIDEO_MSB:0];      // RULE2
            d.par[UNUSED_BIT]   = 1'b0;                                    // RULE2
            d.valid[LANE_FIRST] = 1'b1;
          end
        end
        MODE_DDR_EIGHT: begin
          if (lane_done[LANE_FIRST]) begin
            d.par               = lane_word[LANE_FIRST];                   // RULE3
            d.valid[LANE_FIRST] = 1'b1;
          end
        end
        MODE_DDR_DUAL_FOUR: begin
          if (lane_done[LANE_FIRST]) begin
            d.par[UPPER_MSB:UPPER_LSB] = lane_word[LANE_FIRST][HALF_MSB:0]; // RULE4
            d.valid[LANE_FIRST]        = 1'b1;
          end
          if (lane_done[LANE_THIRD]) begin
            d.par[HALF_MSB:HALF_LSB] = lane_word[LANE_THIRD][HALF_MSB:0];  // RULE4
            d.valid[LANE_THIRD]      = 1'b1;
          end
        end
        default: begin
          d.par = '0;
        end
      endcase
    end
    // One slow period per word: low for the first half of the bits.
    // Odd lengths (video) give a slightly uneven duty cycle.
    d.slow = (lane_cnt[LANE_FIRST] >= (lane_len[LANE_FIRST] >> 1))       // RULE7
             && (lane_len[LANE_FIRST] != LEN_NONE);
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign parallel_q = q.par;
  assign word_valid = q.valid;
  assign slow_clock = q.slow;

endmodule : input_deserializer_gearbox

// File: testbench/gearbox_checker_assertions.sv
`timescale 1ns/1ps
// ====
// Port properties of the input gearbox
module gearbox_checker
  import gearbox_pkg::*;
(
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   reset_n,
  // Inputs
  input wire gearbox_pkg::gear_mode_t mode,
  input wire logic                   fast_edge_clock,
  input wire logic                   serial_first,
  input wire logic                   serial_third,
  input wire logic                   word_align_request,
  input wire logic                   word_align_request_third,
  // Outputs
  input wire logic [gearbox_pkg::PAR_WIDTH-1:0] parallel_q,
  input wire logic [gearbox_pkg::LANE_COUNT-1:0] word_valid,
  input wire logic                   slow_clock
);
  logic [3:0] quiet_q;
  logic       link_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Cycles since the link clock moved; saturates so it never wraps
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      link_q  <= 1'b0;
      quiet_q <= 4'hF;
    end else begin
      link_q  <= fast_edge_clock;
      quiet_q <= (link_q != fast_edge_clock) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hF};
    end
  end
  AST_VIDEO_TOP: assert property (
    mode == MODE_VIDEO_SEVEN && word_valid[0] |-> parallel_q[7] == 1'b0)
    else $error("video word with top bit set");
  AST_THIRD_DUAL: assert property (
    word_valid[1] |-> mode == MODE_DDR_DUAL_FOUR) else $error("third lane word outside dual");
  AST_HALF_KEEP: assert property (
    mode == MODE_DDR_DUAL_FOUR && $stable(mode) && word_valid == 2'b01
    |-> $stable(parallel_q[3:0])) else $error("first lane word touched low half");
  AST_PULSE: assert property (
    word_valid[0] |=> !word_valid[0]) else $error("word strobe longer than a cycle");
  AST_Q_HOLD: assert property (
    word_valid == 2'b00 && $stable(mode) && mode == $past(mode, 3) |-> $stable(parallel_q))
    else $error("parallel word moved without strobe");
  AST_SLOW_WORD: assert property (
    $rose(slow_clock) && mode != MODE_DDR_DUAL_FOUR |-> ##[1:40] word_valid[0])
    else $error("slow clock rose without a word");
  AST_EDGE_WORD: assert property (
    word_valid != 2'b00 |-> quiet_q < 4'h8) else $error("word without link edges");
  AST_IDLE: assert property (
    mode == gear_mode_t'(2'h3) && $stable(mode) |-> word_valid == 2'b00)
    else $error("word in unused mode");
  cover property (word_valid == 2'b11);
  cover property (word_valid == 2'b01 && mode == MODE_DDR_DUAL_FOUR);
  cover property (mode == MODE_VIDEO_SEVEN && word_valid[0]);
endmodule : gearbox_checker

// File: testbench/serial_source.sv
`timescale 1ns/1ps
// ====
// Far-side transmitter: each link edge centred in its bit
module serial_source (
  // Frame request
  input  wire logic        go,
  input  wire logic [15:0] word_a,
  input  wire logic [15:0] word_b,
  input  wire logic [4:0]  nbits,
  // Link pins
  output logic             link_clk = 1'b0,
  output logic             sd_a = 1'b0,
  output logic             sd_b = 1'b1,
  output logic             busy = 1'b0
);
  // MSB first, one bit per edge; clock stands still between frames
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      if (i < nbits) begin
        sd_a = word_a[i];
        sd_b = word_b[i];
        #100;
        link_clk = ~link_clk;
        #100;
      end
    end
    sd_a = ~sd_a; // Released line never keeps the last bit
    sd_b = ~sd_b;
    busy = 1'b0;
  end
endmodule : serial_source

// File: testbench/input_deserializer_gearbox_test.sv
`timescale 1ns/1ps
// ====
// Self-checking bench for the input gearbox
module input_deserializer_gearbox_test;
  import gearbox_pkg::*;
  logic       mclk = 1'b0;
  logic       reset_n = 1'b0;
  gear_mode_t mode = MODE_DDR_EIGHT;
  logic       al_a = 1'b0;
  logic       al_b = 1'b0;
  logic       go = 1'b0;
  logic [15:0] wa = 16'h0;
  logic [15:0] wb = 16'h0;
  logic [4:0] nb = 5'h0;
  logic       lk, sa, sb, busy;
  logic       slw;
  logic       slw_last = 1'b0;
  int         slow_rises = 0;
  logic [7:0] q;
  logic [1:0] vld;
  logic [7:0] got_a[$];
  logic [7:0] got_b[$];
  int         error_cnt = 0;
  int         n_tests = 0;
  int         cycles = 0;
  serial_source src (.go(go), .word_a(wa), .word_b(wb), .nbits(nb), .link_clk(lk),
    .sd_a(sa), .sd_b(sb), .busy(busy));
  input_deserializer_gearbox uut (.mclk(mclk), .reset_n(reset_n), .mode(mode),
    .fast_edge_clock(lk), .serial_first(sa), .serial_third(sb), .word_align_request(al_a),
    .word_align_request_third(al_b), .parallel_q(q), .word_valid(vld), .slow_clock(slw));
  always #25 mclk = ~mclk;
  // Collect words; the ceiling cuts a hang short
  always @(posedge mclk) begin
    if (vld[0] === 1'b1) got_a.push_back(q);
    if (vld[1] === 1'b1) got_b.push_back(q);
    // One slow clock period per first-lane word
    if (slw === 1'b1 && slw_last !== 1'b1) slow_rises++;
    slw_last = slw;
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic set_mode(input gear_mode_t m);
    mode <= m;
    repeat (4) @(posedge mclk);
    got_a.delete();
    got_b.delete();
    slow_rises = 0;
  endtask : set_mode
  task automatic send(input logic [15:0] a, input logic [15:0] b, input logic [4:0] n);
    wa <= a;
    wb <= b;
    nb <= n;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    for (int i = 0; i < 300 && busy; i++) @(posedge mclk);
    repeat (10) @(posedge mclk);
  endtask : send
  task automatic t_modes();
    set_mode(MODE_DDR_EIGHT);
    send(16'hA53C, 16'h0, 5'd16);
    check("n8", 8'(got_a.size()), 8'h02);
    check("w8a", got_a[0], 8'hA5);
    check("w8b", got_a[1], 8'h3C);
    check("s8", 8'(slow_rises), 8'h02);
    set_mode(MODE_VIDEO_SEVEN);
    send(16'h2AAB, 16'h0, 5'd14);
    check("w7a", got_a[0], 8'h55);
    check("w7b", got_a[1], 8'h2B);
    check("s7", 8'(slow_rises), 8'h02);
    set_mode(MODE_DDR_DUAL_FOUR);
    send(16'h00A3, 16'h005C, 5'd8);
    check("d_a", got_a[1], 8'h3C);
    check("d_b", got_b[0][3:0], 8'h05);
    check("d_c", got_a[0][7:4], 8'h0A);
    set_mode(gear_mode_t'(2'h3));
    send(16'h00FF, 16'h0, 5'd8);
    check("idle", 8'(got_a.size()), 8'h00);
  endtask : t_modes
  task automatic t_align();
    set_mode(MODE_DDR_EIGHT);
    al_a <= 1'b1;
    @(posedge mclk);
    al_a <= 1'b0;
    send(16'h0196, 16'h0, 5'd9);
    check("slip8", got_a[0], 8'h96);
    set_mode(MODE_DDR_DUAL_FOUR);
    al_b <= 1'b1;
    @(posedge mclk);
    al_b <= 1'b0;
    send(16'h0015, 16'h0005, 5'd5);
    check("slip_a", got_a[0][7:4], 8'h0A);
    check("slip_b", got_b[0][3:0], 8'h05);
  endtask : t_align
  task complete_run();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    t_modes();
    t_align();
    complete_run();
  end
endmodule : input_deserializer_gearbox_test
bind input_deserializer_gearbox gearbox_checker chk (.mclk(mclk), .reset_n(reset_n),
  .mode(mode), .fast_edge_clock(fast_edge_clock), .serial_first(serial_first),
  .serial_third(serial_third), .word_align_request(word_align_request),
  .word_align_request_third(word_align_request_third), .parallel_q(parallel_q),
  .word_valid(word_valid), .slow_clock(slow_clock));
